// *** core/ppo_timer.sv ***
// Programmable pulse output timer with double-edge capture and interrupt.
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/100ps
// How it works
// - Internal clock counts; start by pin or command.
// - Oneshot bit: zero repeats, one single pulse.
// - Duty match inverts output, interrupts, keeps counting.
// - Period match inverts in pulse mode, interrupts, clears, continues.
// - Start field cleared stops, output holds level.
// - Oneshot period match clears start field itself.
// - Pin is inverse flip-flop; initial level sets.
// - Reset clears the output flip-flop to zero.
// - Capture alternately reports trigger-to-opposite-edge width, full cycle; with the capture edge bit set, opposite edges only.
// - Start field picks rising or falling trigger.
module ppo_timer
	import ppo_pkg::*;
#(
	parameter int COUNT_WIDTH = 16
) (
	input  wire logic                   sys_clk,
	input  wire logic                   reset_n,
	input  wire logic [3:0]             reg_addr,
	input  wire logic [15:0]            reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [15:0]            reg_rdata,
	input  wire logic                   timer_input_pin,
	output logic                        pulse_output_pin,
	output logic                        timer_match_interrupt
);

	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	ppo_bus_req_type           bus;
	logic [7:0]                timer_control_register;
	logic [COUNT_WIDTH-1:0]    period_compare;
	logic [COUNT_WIDTH-1:0]    duty_compare_capture;
	logic [COUNT_WIDTH-1:0]    count;
	logic [15:0]               prescale;
	logic [15:0]               prescale_count;
	logic [3:0]                status;
	logic [3:0]                mask;
	logic                      output_ff;
	logic [2:0]                pin_sync;
	logic                      pin_level;
	logic                      pin_prev;
	logic [4:0]                pin_warm;
	logic                      capture_half;
	ppo_state_type             state;

	logic [1:0]                start_source_field;
	logic                      oneshot_select;
	logic [1:0]                operating_mode_field;
	logic                      capture_edge_select;
	logic                      tick;
	logic                      rise;
	logic                      fall;
	logic                      trigger_edge;
	logic                      opposite_edge;
	logic                      running;
	logic                      duty_hit;
	logic                      period_hit;
	logic                      oneshot_end;
	logic [3:0]                events;
	logic                      status_read;

	// ----------------------------------------------------------------
	// Bus mapping
	// ----------------------------------------------------------------
	assign bus.addr  = reg_addr;
	assign bus.wdata = reg_wdata;
	assign bus.wr    = reg_wr;
	assign bus.rd    = reg_rd;

	// ----------------------------------------------------------------
	// Field decode
	// ----------------------------------------------------------------
	assign start_source_field   = timer_control_register[CTL_START_LO +: 2];
	assign oneshot_select       = timer_control_register[CTL_ONESHOT];
	assign operating_mode_field = timer_control_register[CTL_MODE_LO +: 2];
	assign capture_edge_select  = timer_control_register[CTL_CAP_EDGE];

	// ----------------------------------------------------------------
	// Pin input synchroniser and edge detection
	// ----------------------------------------------------------------
	// A change counts only once the second and third stages agree.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			pin_sync  <= 3'h0;
			pin_level <= 1'b0;
			pin_prev  <= 1'b0;
		end else begin
			pin_sync <= {pin_sync[1:0], timer_input_pin};
			if (pin_sync[1] == pin_sync[2]) begin
				pin_level <= pin_sync[2];
			end
			pin_prev <= pin_level;
		end
	end

	// ----------------------------------------------------------------
	// Trigger edge selection
	// ----------------------------------------------------------------
	// The filter starts from zero, so a pin already high at reset would look like a rise.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			pin_warm <= 5'h00;
		end else begin
			pin_warm <= {pin_warm[3:0], 1'b1};
		end
	end

	assign rise = pin_warm[4] & pin_level & ~pin_prev;
	assign fall = pin_warm[4] & ~pin_level & pin_prev;
	assign trigger_edge  = (start_source_field == START_RISING) ? rise :
		(start_source_field == START_FALLING) ? fall : 1'b0;
	assign opposite_edge = (start_source_field == START_RISING) ? fall :
		(start_source_field == START_FALLING) ? rise : 1'b0;

	// ----------------------------------------------------------------
	// Source clock prescaler
	// ----------------------------------------------------------------
	// The source clock is a tick every prescale+1 system clocks.
	always_ff @(posedge sys_clk) begin
		if (!reset_n || state != PPO_RUN || prescale_count >= prescale) begin
			prescale_count <= 16'h0000;
		end else begin
			prescale_count <= prescale_count + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Match detection
	// ----------------------------------------------------------------
	// A cleared start field halts ticks at once, so the edge after a stop moves nothing.
	assign running = (state == PPO_RUN) && (start_source_field != START_STOP);
	assign tick    = running && (prescale_count >= prescale);

	assign duty_hit    = tick && operating_mode_field == MODE_PULSE
		&& count == duty_compare_capture;
	assign period_hit  = tick && operating_mode_field != MODE_CAPTURE
		&& count == period_compare;
	assign oneshot_end = period_hit && oneshot_select
		&& operating_mode_field == MODE_PULSE;

	// ----------------------------------------------------------------
	// Start sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!reset_n || start_source_field == START_STOP) begin
			state <= PPO_IDLE;
		end else begin
			case (state)
				PPO_IDLE: begin
					if (start_source_field == START_COMMAND) begin
						state <= PPO_RUN;
					end else begin
						state <= PPO_ARMED;
					end
				end
				PPO_ARMED: begin
					if (trigger_edge) begin
						state <= PPO_RUN;
					end
				end
				PPO_RUN: begin
					if (oneshot_end) begin
						state <= PPO_IDLE;
					end
				end
				default: begin
					state <= PPO_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	// Stopping freezes the count until the next start clears it.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			count <= '0;
		end else if (state != PPO_RUN) begin
			if (start_source_field != START_STOP && state == PPO_IDLE) begin
				count <= '0;
			end
		end else if (operating_mode_field == MODE_CAPTURE && capture_half
			&& trigger_edge) begin
			count <= '0;
		end else if (period_hit) begin
			count <= '0;
		end else if (tick) begin
			count <= count + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Control register and oneshot start clear
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			timer_control_register <= CONTROL_RESET;
		end else if (bus.wr && bus.addr == ADDR_CONTROL) begin
			timer_control_register <= bus.wdata[7:0];
		end else if (oneshot_end) begin
			timer_control_register[CTL_START_LO +: 2] <= START_STOP;
		end
	end

	// ----------------------------------------------------------------
	// Period, mask and prescale registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			period_compare <= COMPARE_RESET;
			mask           <= 4'h0;
			prescale       <= PRESCALE_RESET;
		end else if (bus.wr) begin
			if (bus.addr == ADDR_PERIOD) begin
				period_compare <= bus.wdata[COUNT_WIDTH-1:0];
			end
			if (bus.addr == ADDR_MASK) begin
				mask <= bus.wdata[3:0];
			end
			if (bus.addr == ADDR_PRESCALE) begin
				prescale <= bus.wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Capture
	// ----------------------------------------------------------------
	// Duty compare doubles as the capture register in capture mode.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			duty_compare_capture <= COMPARE_RESET;
		end else if (running && operating_mode_field == MODE_CAPTURE
			&& (opposite_edge && !capture_half || trigger_edge && capture_half)) begin
			duty_compare_capture <= count;
		end else if (bus.wr && bus.addr == ADDR_DUTY) begin
			duty_compare_capture <= bus.wdata[COUNT_WIDTH-1:0];
		end
	end

	// Alternates between trigger-to-opposite-edge width and full cycle reports while the capture edge bit is clear.
	always_ff @(posedge sys_clk) begin
		if (!reset_n || !running || operating_mode_field != MODE_CAPTURE
			|| capture_edge_select) begin
			capture_half <= 1'b0;
		end else if (!capture_half && opposite_edge) begin
			capture_half <= 1'b1;
		end else if (capture_half && trigger_edge) begin
			capture_half <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Timer output flip-flop
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			output_ff <= 1'b0;
		end else if (bus.wr && bus.addr == ADDR_CONTROL && state == PPO_IDLE
			&& bus.wdata[CTL_MODE_LO +: 2] == MODE_PULSE
			&& operating_mode_field != MODE_PULSE) begin
			output_ff <= bus.wdata[CTL_INIT_LEVEL];
		end else if (duty_hit || period_hit && operating_mode_field == MODE_PULSE) begin
			output_ff <= ~output_ff;
		end
	end

	// ----------------------------------------------------------------
	// Pulse output pin
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			pulse_output_pin <= 1'b1;
		end else begin
			pulse_output_pin <= ~output_ff;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status
	// ----------------------------------------------------------------
	assign events[ST_DUTY_MATCH]   = duty_hit;
	assign events[ST_PERIOD_MATCH] = period_hit;
	assign events[ST_CAPTURE]      = running && operating_mode_field == MODE_CAPTURE
		&& !capture_half && opposite_edge;
	assign events[ST_WIDTH]        = running && operating_mode_field == MODE_CAPTURE
		&& capture_half && trigger_edge;
	assign status_read = bus.rd && bus.addr == ADDR_STATUS;

	// A new event in the reading cycle survives the clear.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			status <= 4'h0;
		end else if (status_read) begin
			status <= events;
		end else begin
			status <= status | events;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt output
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			timer_match_interrupt <= 1'b0;
		end else begin
			timer_match_interrupt <= |((status_read ? events : (status | events)) & mask);
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!reset_n || !bus.rd) begin
			reg_rdata <= 16'h0000;
		end else begin
			case (bus.addr)
				ADDR_CONTROL:  reg_rdata <= {8'h00, timer_control_register};
				ADDR_PERIOD:   reg_rdata <= 16'(period_compare);
				ADDR_DUTY:     reg_rdata <= 16'(duty_compare_capture);
				ADDR_COUNT:    reg_rdata <= 16'(count);
				ADDR_STATUS:   reg_rdata <= {12'h000, status};
				ADDR_MASK:     reg_rdata <= {12'h000, mask};
				ADDR_PRESCALE: reg_rdata <= prescale;
				default:       reg_rdata <= 16'h0000;
			endcase
		end
	end

endmodule

// *** core/ppo_pkg.sv ***
// Package for the programmable pulse output timer: offsets, fields, resets.
package ppo_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_CONTROL  = 4'h0;
	localparam logic [3:0] ADDR_PERIOD   = 4'h1;
	localparam logic [3:0] ADDR_DUTY     = 4'h2;
	localparam logic [3:0] ADDR_COUNT    = 4'h3;
	localparam logic [3:0] ADDR_STATUS   = 4'h4;
	localparam logic [3:0] ADDR_MASK     = 4'h5;
	localparam logic [3:0] ADDR_PRESCALE = 4'h6;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CTL_START_LO   = 0;
	localparam int CTL_ONESHOT    = 2;
	localparam int CTL_INIT_LEVEL = 3;
	localparam int CTL_MODE_LO    = 4;
	localparam int CTL_CAP_EDGE   = 6;

	localparam logic [1:0] START_STOP    = 2'h0;
	localparam logic [1:0] START_COMMAND = 2'h1;
	localparam logic [1:0] START_RISING  = 2'h2;
	localparam logic [1:0] START_FALLING = 2'h3;

	localparam logic [1:0] MODE_TIMER   = 2'h0;
	localparam logic [1:0] MODE_PULSE   = 2'h1;
	localparam logic [1:0] MODE_CAPTURE = 2'h2;

	// ----------------------------------------------------------------
	// Status bits and reset values
	// ----------------------------------------------------------------
	localparam int ST_DUTY_MATCH   = 0;
	localparam int ST_PERIOD_MATCH = 1;
	localparam int ST_CAPTURE      = 2;
	localparam int ST_WIDTH        = 3;

	localparam logic [7:0]  CONTROL_RESET  = 8'h00;
	localparam logic [15:0] COMPARE_RESET  = 16'hFFFF;
	localparam logic [15:0] PRESCALE_RESET = 16'h0000;

	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} ppo_bus_req_type;

	typedef enum logic [1:0] {
		PPO_IDLE,
		PPO_ARMED,
		PPO_RUN
	} ppo_state_type;

endpackage

// *** tb/ppo_timer_chk.sv ***
// Port checker of the pulse output timer.
`timescale 1ns/100ps
module ppo_timer_chk
	import ppo_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        reset_n,
	input wire logic [3:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        timer_input_pin,
	input wire logic        pulse_output_pin,
	input wire logic        timer_match_interrupt
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence cnt_rd;
		reg_rd && reg_addr == ADDR_COUNT;
	endsequence
	// Reset holds the pin high, the interrupt low and the read data zero.
	a_reset_state: assert property (disable iff (1'b0) !reset_n |=> pulse_output_pin
		&& !timer_match_interrupt && reg_rdata == 16'h0000) else $error("reset state wrong");
	a_release_high: assert property ($rose(reset_n) |-> pulse_output_pin [*3])
		else $error("pin low after reset");
	// A match on the stopping edge itself shows on the pin one edge later.
	a_stop_holds: assert property (reg_wr && reg_addr == ADDR_CONTROL
		&& reg_wdata[1:0] == START_STOP && reg_wdata[5:4] == MODE_PULSE
		|-> ##3 $stable(pulse_output_pin) [*6]) else $error("pin moved after stop");
	a_unmapped_zero: assert property (reg_rd && reg_addr > ADDR_PRESCALE |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_control_upper: assert property (reg_rd && reg_addr == ADDR_CONTROL
		|=> reg_rdata[15:8] == 8'h00) else $error("control upper bits set");
	a_read_once: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data without read");
	a_count_step: assert property (cnt_rd ##1 cnt_rd |=> reg_rdata == 16'h0000
		|| reg_rdata == $past(reg_rdata) || reg_rdata == $past(reg_rdata) + 16'h0001)
		else $error("count jumped");
	property period_echo;
		logic [15:0] d;
		(reg_wr && reg_addr == ADDR_PERIOD, d = reg_wdata) ##2
		(reg_rd && reg_addr == ADDR_PERIOD) |=> reg_rdata == d;
	endproperty
	a_period_echo: assert property (period_echo) else $error("period readback wrong");
	a_mask_quiet: assert property (reg_wr && reg_addr == ADDR_MASK && reg_wdata == 16'h0000
		|-> ##2 !timer_match_interrupt [*2]) else $error("irq while masked");
	cover property ($fell(pulse_output_pin));
	cover property ($rose(timer_match_interrupt));
	cover property (cnt_rd ##1 cnt_rd);
endmodule
bind ppo_timer ppo_timer_chk i_chk (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .timer_input_pin, .pulse_output_pin, .timer_match_interrupt);

// *** tb/ppo_far_end.sv ***
// Model of the far-end circuit that drives the timer input pin.
`timescale 1ns/100ps
module ppo_far_end #(
	parameter int LOW_CYCLES  = 30,
	parameter int HIGH_CYCLES = 20
) (
	input  wire logic sys_clk,
	input  wire logic run,
	output logic      timer_input_pin
);
	int phase = 0;
	initial timer_input_pin = 1'b0;
	// A driven pin, so it rests low rather than floating between runs.
	always @(posedge sys_clk) begin
		phase <= run ? (phase + 1) % (LOW_CYCLES + HIGH_CYCLES) : 0;
		timer_input_pin <= run && phase >= LOW_CYCLES;
	end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench of the pulse output timer.
`timescale 1ns/100ps
module testbench
	import ppo_pkg::*;
;
	localparam int P = 20;
	localparam int D = 8;
	localparam int P2 = P + 4;
	logic        sys_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        run = 1'b0;
	logic [15:0] reg_rdata;
	logic        timer_input_pin;
	logic        pulse_output_pin;
	logic        timer_match_interrupt;
	logic [15:0] v;
	logic [15:0] s;
	logic [15:0] t;
	logic [3:0]  ra[7] = '{ADDR_CONTROL, ADDR_PERIOD, ADDR_DUTY, ADDR_STATUS, ADDR_MASK,
		ADDR_PRESCALE, 4'h7};
	logic [15:0] rv[7] = '{16'(CONTROL_RESET), COMPARE_RESET, COMPARE_RESET, 16'h0000, 16'h0000,
		PRESCALE_RESET, 16'h0000};
	int          n;
	int          bad_count = 0;
	int          n_tests = 0;
	int          cycles = 0;
	ppo_timer i_dut (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.timer_input_pin, .pulse_output_pin, .timer_match_interrupt);
	ppo_far_end i_far (.sys_clk, .run, .timer_input_pin);
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// A hung wait counts as a mismatch and still reaches the report.
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rc(input logic [3:0] a, input logic [15:0] e, input string w);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
		if (w != "") chk(v, e, w);
	endtask
	task automatic span(input logic lvl, output int k);
		k = 0;
		while (pulse_output_pin === lvl && k < 300) begin
			tick(1);
			k++;
		end
	endtask
	initial begin
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		foreach (ra[i]) rc(ra[i], rv[i], "reset value");
		chk(pulse_output_pin, 1'b1, "pin after reset");
		wr(ADDR_CONTROL, 16'h0010);
		wr(ADDR_PERIOD, 16'(P));
		rc(ADDR_PERIOD, 16'(P), "period");
		wr(ADDR_DUTY, 16'(D));
		wr(ADDR_MASK, 16'h000F);
		tick(11);
		wr(ADDR_CONTROL, 16'h0011);
		span(1'b1, n);
		span(1'b0, n);
		chk(n, P - D, "low width");
		span(1'b1, n);
		chk(n, D + 1, "high width");
		chk(timer_match_interrupt, 1'b1, "irq");
		rc(ADDR_STATUS, 16'h0003, "status");
		wr(ADDR_PERIOD, 16'(P2));
		@(posedge sys_clk);
		reg_addr <= ADDR_COUNT;
		reg_rd <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reg_rd <= 1'b0;
		span(1'b0, n);
		span(1'b1, n);
		span(1'b0, n);
		chk(n, P2 - D, "new period");
		span(1'b1, n);
		wr(ADDR_CONTROL, 16'h0010);
		wr(ADDR_MASK, 16'h0000);
		tick(20);
		chk(pulse_output_pin, 1'b0, "held after stop");
		chk(timer_match_interrupt, 1'b0, "masked irq");
		wr(ADDR_CONTROL, 16'h0000);
		wr(ADDR_CONTROL, 16'h0010);
		tick(11);
		chk(pulse_output_pin, 1'b1, "level zero");
		wr(ADDR_CONTROL, 16'h0000);
		wr(ADDR_CONTROL, 16'h0018);
		tick(11);
		chk(pulse_output_pin, 1'b0, "level one");
		wr(ADDR_CONTROL, 16'h001D);
		span(1'b0, n);
		span(1'b1, n);
		chk(n, P2 - D, "single width");
		tick(2 * P);
		chk(pulse_output_pin, 1'b0, "single end");
		rc(ADDR_CONTROL, 16'h001C, "start cleared");
		wr(ADDR_MASK, 16'h000F);
		tick(3);
		chk(timer_match_interrupt, 1'b1, "irq raised");
		rc(ADDR_STATUS, 16'h0003, "single status");
		tick(3);
		chk(timer_match_interrupt, 1'b0, "irq cleared");
		wr(ADDR_CONTROL, 16'h0001);
		tick(2 * P2);
		chk(pulse_output_pin, 1'b0, "timer mode pin");
		rc(ADDR_STATUS, 16'h0002, "timer status");
		wr(ADDR_CONTROL, 16'h0000);
		wr(ADDR_CONTROL, 16'h0010);
		tick(11);
		wr(ADDR_CONTROL, 16'h0013);
		@(posedge sys_clk);
		run <= 1'b1;
		tick(50);
		chk(pulse_output_pin, 1'b1, "no start on rise");
		span(1'b1, n);
		chk(pulse_output_pin, 1'b0, "start on fall");
		wr(ADDR_CONTROL, 16'h0000);
		wr(ADDR_CONTROL, 16'h0022);
		rc(ADDR_STATUS, 16'h0000, "");
		s = 16'h0000;
		for (int i = 0; i < 6; i++) begin
			n = 0;
			while (timer_match_interrupt !== 1'b1 && n < 300) begin
				tick(1);
				n++;
			end
			t = s;
			rc(ADDR_STATUS, 16'h0000, "");
			s = v;
			rc(ADDR_DUTY, 16'h0000, "");
			if (i > 1) begin
				chk(s, t ^ 16'h000C, "alternate");
				chk(v >= (s == 16'h0004 ? 16'h0012 : 16'h0030) && v <= (s == 16'h0004
					? 16'h0016 : 16'h0034), 1'b1, "capture");
			end
		end
		tally_and_finish();
	end
endmodule
